/* dadc_pkg.sv */
package dadc_pkg;

	// Converter geometry
	localparam int unsigned WORD_W      = 12;
	localparam int unsigned PIPE_STAGES = 6;
	localparam int unsigned BUF_DEPTH   = 2;
	localparam int unsigned BUF_W       = 2 * WORD_W;

	// Sample clock, 25 MHz
	localparam int unsigned CLK_HZ      = 25000000;
	localparam int unsigned MIN_RATE_SPS = 66000000;

	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_MISSED   = 8'h08;

	// Control fields
	localparam int unsigned CTRL_RUN_BIT = 0;
	localparam int unsigned CTRL_CLR_BIT = 1;
	localparam logic        CTRL_RUN_RST = 1'b1;

	// Status fields
	localparam int unsigned ST_ASLEEP_BIT = 0;
	localparam int unsigned ST_TWOS_BIT   = 1;
	localparam int unsigned ST_EXTREF_BIT = 2;
	localparam int unsigned ST_VALID_BIT  = 3;
	localparam int unsigned ST_FULL_BIT   = 4;

	// Missed-sample counter
	localparam int unsigned MISS_W        = 16;
	localparam logic [15:0] MISS_RST      = 16'h0000;

	// Two-flop synchroniser depth for pins
	localparam int unsigned SYNC_STAGES   = 2;

	// Operating mode
	typedef enum logic {
		DADC_ACTIVE,
		DADC_ASLEEP
	} dadc_mode_type;

endpackage : dadc_pkg

/* dadc_port.sv */
`timescale 1ns/10ps
// How it works
// - Samples are taken only on the rising edge of the sample clock.
// - A sample's result appears on the output bus six clock edges later.
// - Each channel has its own 12-bit result bus.
// - One word per channel leaves every clock while the receiver keeps up.
// - A low output enable makes that channel drive its data pins.
// - A high output enable floats that channel's pins, independent of the other.
// - Sleep request high stops conversion and empties the pipeline.
// - Sleep request low keeps the converter in normal conversion.
// - Format select low gives offset binary, high gives two's complement.
// - Reference select low uses the internal reference, high an external one.
// - Result bit 0 is the LSB and bit 11 the MSB on both buses.
module dadc_port (
	// Clock and reset
	input  wire logic                      ref_clk_i,
	input  wire logic                      nrst_i,
	// Converter core samples, same clock, offset binary
	input  wire logic [dadc_pkg::WORD_W-1:0] chan_a_sample_i,
	input  wire logic [dadc_pkg::WORD_W-1:0] chan_b_sample_i,
	output logic                           core_ready_o,
	// Control pins
	input  wire logic                      chan_a_output_enable_n_i,
	input  wire logic                      chan_b_output_enable_n_i,
	input  wire logic                      sleep_request_i,
	input  wire logic                      number_format_select_i,
	input  wire logic                      reference_source_select_i,
	output logic                           reference_internal_en_o,
	// Result buses
	output logic [dadc_pkg::WORD_W-1:0]    chan_a_result_bus_o,
	output logic [dadc_pkg::WORD_W-1:0]    chan_a_result_oe_o,
	output logic [dadc_pkg::WORD_W-1:0]    chan_b_result_bus_o,
	output logic [dadc_pkg::WORD_W-1:0]    chan_b_result_oe_o,
	output logic                           result_valid_o,
	input  wire logic                      result_ready_i,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [7:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output logic [31:0]                    prdata,
	output logic                           pready,
	output logic                           pslverr
);

	localparam int unsigned W  = dadc_pkg::WORD_W;
	localparam int unsigned NS = dadc_pkg::PIPE_STAGES;
	localparam int unsigned SS = dadc_pkg::SYNC_STAGES;

	logic [SS-1:0]          oe_a_sync;
	logic [SS-1:0]          oe_b_sync;
	logic [SS-1:0]          sleep_sync;
	logic [SS-1:0]          fmt_sync;
	logic [SS-1:0]          ref_sync;
	dadc_pkg::dadc_mode_type mode;
	logic                   run_en;
	logic                   clr_req;
	logic [dadc_pkg::MISS_W-1:0] missed;
	logic                   pipe_adv;
	logic                   buf_in_ready;
	logic                   buf_take;
	logic [NS-1:0]          stage_vld;
	logic [W-1:0]           stage_a [NS];
	logic [W-1:0]           stage_b [NS];
	logic [W-1:0]           cap_a;
	logic [W-1:0]           cap_b;
	logic [dadc_pkg::BUF_W-1:0] buf_mem [dadc_pkg::BUF_DEPTH];
	logic                   wr_ptr;
	logic                   rd_ptr;
	logic [1:0]             buf_count;
	logic                   apb_setup;
	logic                   apb_write;
	logic                   addr_ok;
	logic [31:0]            next_rdata;

	// Pin synchronisers; only the last flop is read
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			oe_a_sync  <= '1;
			oe_b_sync  <= '1;
			sleep_sync <= '0;
			fmt_sync   <= '0;
			ref_sync   <= '0;
		end
		else
		begin
			oe_a_sync  <= {oe_a_sync[0], chan_a_output_enable_n_i};
			oe_b_sync  <= {oe_b_sync[0], chan_b_output_enable_n_i};
			sleep_sync <= {sleep_sync[0], sleep_request_i};
			fmt_sync   <= {fmt_sync[0], number_format_select_i};
			ref_sync   <= {ref_sync[0], reference_source_select_i};
		end
	end

	// Operating mode follows the sleep pin
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			mode <= dadc_pkg::DADC_ACTIVE;
		else if (sleep_sync[SS-1])
			mode <= dadc_pkg::DADC_ASLEEP;
		else
			mode <= dadc_pkg::DADC_ACTIVE;
	end

	// Internal reference off when an external one is chosen
	assign reference_internal_en_o = !ref_sync[SS-1];

	// Pipeline moves only when the buffer has room, so no word is lost
	assign buf_in_ready = (buf_count != 2'd2);
	assign pipe_adv     = buf_in_ready;
	assign core_ready_o = buf_in_ready && run_en && (mode == dadc_pkg::DADC_ACTIVE);

	// Format conversion at capture: flipping the MSB gives two's complement
	assign cap_a = {chan_a_sample_i[W-1] ^ fmt_sync[SS-1], chan_a_sample_i[W-2:0]};
	assign cap_b = {chan_b_sample_i[W-1] ^ fmt_sync[SS-1], chan_b_sample_i[W-2:0]};

	// First stage: capture on the rising edge only
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			stage_vld[0] <= 1'b0;
			stage_a[0]   <= '0;
			stage_b[0]   <= '0;
		end
		else if (mode == dadc_pkg::DADC_ASLEEP)
			stage_vld[0] <= 1'b0;
		else if (pipe_adv)
		begin
			stage_vld[0] <= run_en;
			stage_a[0]   <= cap_a;
			stage_b[0]   <= cap_b;
		end
	end

	// Remaining delay stages, fixed length for a constant latency
	genvar gi;
	generate
		for (gi = 1; gi < NS; gi++)
		begin : g_stage
			always_ff @(posedge ref_clk_i or negedge nrst_i)
			begin
				if (!nrst_i)
				begin
					stage_vld[gi] <= 1'b0;
					stage_a[gi]   <= '0;
					stage_b[gi]   <= '0;
				end
				else if (mode == dadc_pkg::DADC_ASLEEP)
					stage_vld[gi] <= 1'b0;
				else if (pipe_adv)
				begin
					stage_vld[gi] <= stage_vld[gi-1];
					stage_a[gi]   <= stage_a[gi-1];
					stage_b[gi]   <= stage_b[gi-1];
				end
			end
		end
	endgenerate

	// Two-entry output buffer absorbs receiver stalls
	assign buf_take = result_valid_o && result_ready_i;

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wr_ptr     <= 1'b0;
			rd_ptr     <= 1'b0;
			buf_count  <= 2'd0;
			buf_mem[0] <= '0;
			buf_mem[1] <= '0;
		end
		else
		begin
			if (stage_vld[NS-1] && buf_in_ready)
			begin
				buf_mem[wr_ptr] <= {stage_b[NS-1], stage_a[NS-1]};
				wr_ptr          <= !wr_ptr;
			end
			if (buf_take)
				rd_ptr <= !rd_ptr;
			buf_count <= buf_count + 2'(stage_vld[NS-1] && buf_in_ready) - 2'(buf_take);
		end
	end

	// Head entry drives both buses, LSB on bit 0
	assign result_valid_o      = (buf_count != 2'd0);
	assign chan_a_result_bus_o = buf_mem[rd_ptr][W-1:0];
	assign chan_b_result_bus_o = buf_mem[rd_ptr][2*W-1:W];

	// Per-channel pin drive enables
	assign chan_a_result_oe_o = {W{!oe_a_sync[SS-1]}};
	assign chan_b_result_oe_o = {W{!oe_b_sync[SS-1]}};

	// APB decode; zero wait states, data latched in the setup cycle
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pwrite;
	assign addr_ok   = (paddr == dadc_pkg::OFS_CTRL) || (paddr == dadc_pkg::OFS_STATUS)
	                || (paddr == dadc_pkg::OFS_MISSED);
	assign pready    = 1'b1;

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		unique case (paddr)
			dadc_pkg::OFS_CTRL:
				next_rdata[dadc_pkg::CTRL_RUN_BIT] = run_en;
			dadc_pkg::OFS_STATUS:
			begin
				next_rdata[dadc_pkg::ST_ASLEEP_BIT] = (mode == dadc_pkg::DADC_ASLEEP);
				next_rdata[dadc_pkg::ST_TWOS_BIT]   = fmt_sync[SS-1];
				next_rdata[dadc_pkg::ST_EXTREF_BIT] = ref_sync[SS-1];
				next_rdata[dadc_pkg::ST_VALID_BIT]  = result_valid_o;
				next_rdata[dadc_pkg::ST_FULL_BIT]   = !buf_in_ready;
			end
			dadc_pkg::OFS_MISSED:
				next_rdata[dadc_pkg::MISS_W-1:0] = missed;
			default:
				next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data and error answer registered at setup
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (apb_setup)
		begin
			prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
			pslverr <= !addr_ok;
		end
	end

	// Control register; clear bit is a one-cycle pulse
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			run_en  <= dadc_pkg::CTRL_RUN_RST;
			clr_req <= 1'b0;
		end
		else
		begin
			clr_req <= apb_write && (paddr == dadc_pkg::OFS_CTRL) && pwdata[dadc_pkg::CTRL_CLR_BIT];
			if (apb_write && (paddr == dadc_pkg::OFS_CTRL))
				run_en <= pwdata[dadc_pkg::CTRL_RUN_BIT];
		end
	end

	// Samples refused by a full buffer; a new miss beats a clear
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			missed <= dadc_pkg::MISS_RST;
		else if (run_en && mode == dadc_pkg::DADC_ACTIVE && !buf_in_ready)
			missed <= clr_req ? 16'h0001 : (missed == 16'hffff ? missed : missed + 16'h0001);
		else if (clr_req)
			missed <= dadc_pkg::MISS_RST;
	end

	// Checks; a wake may raise core ready one edge after sleep, so sleep is checked same edge
	chk_capture_edge: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(mode == dadc_pkg::DADC_ACTIVE && run_en && pipe_adv) |=> stage_vld[0])
		else $error("capture missed on rising edge");

	chk_fixed_latency: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(pipe_adv && mode == dadc_pkg::DADC_ACTIVE)[*6]
		|=> stage_a[5] == $past(stage_a[0], 5))
		else $error("pipeline delay wrong");

	chk_bus_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(result_valid_o && !result_ready_i) |=>
		($stable(chan_a_result_bus_o) && $stable(chan_b_result_bus_o)))
		else $error("result changed during stall");

	chk_full_rate: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(stage_vld[5] && result_ready_i && mode == dadc_pkg::DADC_ACTIVE)
		|=> result_valid_o)
		else $error("word not delivered");

	chk_drive_low: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(!chan_a_output_enable_n_i)[*3] |-> chan_a_result_oe_o == '1)
		else $error("channel a not driving");

	chk_drive_chan_b: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(!chan_b_output_enable_n_i)[*3] |-> chan_b_result_oe_o == '1)
		else $error("channel b not driving");

	chk_float_high: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(chan_b_output_enable_n_i && !chan_a_output_enable_n_i)[*3]
		|-> (chan_b_result_oe_o == '0 && chan_a_result_oe_o == '1))
		else $error("enables not independent");

	chk_sleep_stop: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(mode == dadc_pkg::DADC_ASLEEP) |-> (!core_ready_o ##1 (stage_vld == '0)))
		else $error("conversion while asleep");

	chk_active_mode: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(!sleep_request_i)[*3] |=> mode == dadc_pkg::DADC_ACTIVE)
		else $error("not active");

	chk_format_msb: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(mode == dadc_pkg::DADC_ACTIVE && pipe_adv) |=>
		stage_a[0][W-1] == ($past(chan_a_sample_i[W-1]) ^ $past(fmt_sync[SS-1])))
		else $error("format wrong");

	chk_ref_select: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		reference_source_select_i[*3] |-> !reference_internal_en_o)
		else $error("internal reference left on");

	chk_ref_internal: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(!reference_source_select_i)[*3] |-> reference_internal_en_o)
		else $error("internal reference not on");

	chk_bit_order: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(buf_count == 2'd0 && stage_vld[5] && mode == dadc_pkg::DADC_ACTIVE)
		|=> (chan_a_result_bus_o == $past(stage_a[5])
		&& chan_b_result_bus_o == $past(stage_b[5])))
		else $error("bus bit order wrong");

	// Main scenarios worth seeing at least once
	cov_stream: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
		buf_take [*4]);
	cov_stall_full: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
		buf_count == 2'd2);
	cov_sleep_wake: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
		mode == dadc_pkg::DADC_ASLEEP ##1 mode == dadc_pkg::DADC_ACTIVE);
	cov_twos_stream: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
		fmt_sync[SS-1] && buf_take);
	cov_a_floating: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
		chan_a_result_oe_o == '0 && chan_b_result_oe_o == '1);

endmodule : dadc_port

/* dadc_rx_model.sv */
`timescale 1ns/10ps
// Receiver of the result buses; pairs A and B words per edge
module dadc_rx_model (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	// Result buses
	input  wire logic [11:0] a_bus_i,
	input  wire logic [11:0] a_oe_i,
	input  wire logic [11:0] b_bus_i,
	input  wire logic [11:0] b_oe_i,
	input  wire logic        valid_i,
	output logic             ready_o,
	// Bench control
	input  wire logic        stall_i
);
	logic [11:0] a_last;
	logic [11:0] b_last;
	logic [11:0] a_line;
	logic [11:0] b_line;
	int          cyc;
	logic [23:0] got_q[$];
	int          got_t[$];

	// Undriven lines flip, so a floating bus never passes as data
	assign a_line = (a_bus_i & a_oe_i) | (~a_last & ~a_oe_i);
	assign b_line = (b_bus_i & b_oe_i) | (~b_last & ~b_oe_i);
	assign ready_o = !stall_i;

	// Take both words on one sample clock edge
	always @(posedge ref_clk_i)
	begin
		cyc <= cyc + 1;
		a_last <= a_line;
		b_last <= b_line;
		if (nrst_i && valid_i === 1'b1 && ready_o)
		begin
			got_q.push_back({a_line, b_line});
			got_t.push_back(cyc);
		end
	end
endmodule : dadc_rx_model

/* test_dual_adc_digital_port.sv */
`timescale 1ns/10ps
module test_dual_adc_digital_port;
	logic        clk;
	logic        nrst;
	logic [11:0] sa, sb, cnt;
	logic [11:0] abus, aoe, bbus, boe;
	logic        core_rdy, valid, ready, stall;
	logic        a_en_n, b_en_n, slp, fmt, rsel, ref_en;
	logic        psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] exp_q[$];
	int          exp_t[$];
	int          cyc;
	int          bad_count;
	int          comparisons;

	dadc_port u_dut (
		.ref_clk_i(clk), .nrst_i(nrst),
		.chan_a_sample_i(sa), .chan_b_sample_i(sb), .core_ready_o(core_rdy),
		.chan_a_output_enable_n_i(a_en_n), .chan_b_output_enable_n_i(b_en_n),
		.sleep_request_i(slp), .number_format_select_i(fmt),
		.reference_source_select_i(rsel), .reference_internal_en_o(ref_en),
		.chan_a_result_bus_o(abus), .chan_a_result_oe_o(aoe),
		.chan_b_result_bus_o(bbus), .chan_b_result_oe_o(boe),
		.result_valid_o(valid), .result_ready_i(ready),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
	);

	dadc_rx_model u_rx (
		.ref_clk_i(clk), .nrst_i(nrst), .a_bus_i(abus), .a_oe_i(aoe),
		.b_bus_i(bbus), .b_oe_i(boe), .valid_i(valid), .ready_o(ready),
		.stall_i(stall)
	);

	// Sample clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	function automatic logic [11:0] fmt_of(input logic [11:0] v);
		return fmt ? {~v[11], v[10:0]} : v;
	endfunction : fmt_of

	// Ramp into the core; expect each sample the core takes
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		cnt <= cnt + 12'h001;
		sa <= cnt;
		sb <= cnt ^ 12'ha5c;
		if (nrst && core_rdy === 1'b1)
		begin
			exp_q.push_back({fmt_of(sa), fmt_of(sb)});
			exp_t.push_back(cyc);
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One APB transfer; waits for pready, no fixed latency assumed
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task close_out;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	// Hang guard, far beyond the roughly 180 cycles needed
	initial
	begin
		repeat (3000) @(posedge clk);
		bad_count++;
		close_out();
	end

	initial
	begin
		{nrst, psel, penable, pwrite, stall, a_en_n, b_en_n, slp, fmt, rsel} = '0;
		{paddr, pwdata, sa, sb, cnt} = '0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		apb(1'b0, dadc_pkg::OFS_CTRL, 32'h0);
		chk(32'(rd[0]), 32'h1);
		apb(1'b0, dadc_pkg::OFS_MISSED, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h0c, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		$display("test reset_regs done");
		// Prompt receiver: fixed latency, one word per clock
		repeat (40) @(posedge clk);
		chk(32'(u_rx.got_t[0] - exp_t[0]), 32'd7);
		chk(32'(u_rx.got_t[20] - u_rx.got_t[19]), 32'd1);
		$display("test latency done");
		// Receiver stalls long enough to fill the buffer
		stall <= 1'b1;
		repeat (20) @(posedge clk);
		apb(1'b0, dadc_pkg::OFS_STATUS, 32'h0);
		chk(32'(rd[4:3]), 32'h3);
		stall <= 1'b0;
		repeat (5) @(posedge clk);
		apb(1'b0, dadc_pkg::OFS_MISSED, 32'h0);
		chk(32'(rd != 0), 32'h1);
		apb(1'b1, dadc_pkg::OFS_CTRL, 32'h3);
		apb(1'b0, dadc_pkg::OFS_MISSED, 32'h0);
		chk(rd, 32'h0);
		$display("test stall done");
		// Pins change only while the stream is paused and drained
		apb(1'b1, dadc_pkg::OFS_CTRL, 32'h0);
		repeat (12) @(posedge clk);
		fmt <= 1'b1;
		rsel <= 1'b1;
		a_en_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk({aoe, boe, 7'h0, ref_en}, 32'h000fff00);
		apb(1'b0, dadc_pkg::OFS_STATUS, 32'h0);
		chk(32'(rd[2:1]), 32'h3);
		a_en_n <= 1'b0;
		b_en_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk({aoe, boe}, 24'hfff000);
		b_en_n <= 1'b0;
		slp <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b1, dadc_pkg::OFS_CTRL, 32'h1);
		chk(32'(core_rdy), 32'h0);
		apb(1'b0, dadc_pkg::OFS_STATUS, 32'h0);
		chk(32'(rd[0]), 32'h1);
		slp <= 1'b0;
		repeat (4) @(posedge clk);
		chk(32'(core_rdy), 32'h1);
		repeat (30) @(posedge clk);
		apb(1'b1, dadc_pkg::OFS_CTRL, 32'h0);
		repeat (20) @(posedge clk);
		$display("test pins_sleep done");
		// Every taken sample arrives once, in order, both formats
		chk(u_rx.got_q.size(), exp_q.size());
		foreach (exp_q[i])
			chk(u_rx.got_q[i], exp_q[i]);
		$display("test stream done");
		close_out();
	end
endmodule : test_dual_adc_digital_port
